// ==== hdl/rcc_pkg.sv ====
// Constants shared by the retry status and card control register block
package rcc_pkg;

	// ****************************************************************
	// Register offsets in configuration space
	// ****************************************************************
	localparam logic [7:0] RETRY_OFS   = 8'h90;
	localparam logic [7:0] CARD_OFS    = 8'h91;

	// ****************************************************************
	// Values after reset
	// ****************************************************************
	localparam logic [7:0] RETRY_RESET = 8'hC0;
	localparam logic [7:0] CARD_RESET  = 8'h00;

	// ****************************************************************
	// Field positions of the retry timeout status register
	// ****************************************************************
	localparam int HOST_ON_BIT  = 7;
	localparam int CARD_ON_BIT  = 6;
	localparam int TGT_B_BIT    = 5;
	localparam int TGT_A_BIT    = 3;
	localparam int HOST_EXP_BIT = 1;

	// ****************************************************************
	// Field positions of the card socket control register
	// ****************************************************************
	localparam int RING_EN_BIT  = 7;
	localparam int VIDEO_BIT    = 6;
	localparam int SPARE_BIT    = 5;
	localparam int AUDIO_BIT    = 2;
	localparam int SPK_BIT      = 1;
	localparam int IRQ_BIT      = 0;

	// ****************************************************************
	// Retry targets and timeout length
	// ****************************************************************
	localparam int TGT_HOST     = 0;
	localparam int TGT_CARD_A   = 1;
	localparam int TGT_CARD_B   = 2;
	localparam int NUM_TGT      = 3;
	localparam int NUM_SOCK     = 2;
	// Timeout is printed as a power of two of PCI clocks
	localparam int RETRY_TIMEOUT_EXP    = 15;
	localparam int RETRY_TIMEOUT_CLOCKS = 2 ** RETRY_TIMEOUT_EXP;

	// Retry timer states
	typedef enum logic {TMR_IDLE, TMR_WAIT} rcc_tmr_state_t;

endpackage

// ==== hdl/rcc_retry_timer.sv ====
// Retry timeout counter for one retried master
module rcc_retry_timer #(
	parameter int LIMIT = rcc_pkg::RETRY_TIMEOUT_CLOCKS
) (
	input  wire logic clk,     // Clock
	input  wire logic rst,     // Synchronous reset
	input  wire logic issue,   // Retry given to master
	input  wire logic ret,     // Master came back
	input  wire logic enable,  // Counter enable
	output logic      expire   // One-cycle timeout pulse
);
	localparam int CW = $clog2(LIMIT + 1);
	localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

	typedef struct packed {
		rcc_pkg::rcc_tmr_state_t state;
		logic [CW-1:0]           cnt;
		logic                    expire;
	} rcc_tmr_t;

	rcc_tmr_t s_ff;
	rcc_tmr_t nxt_s;

	// Count while waiting; a new retry restarts the wait
	always_comb begin
		nxt_s = s_ff;
		nxt_s.expire = 1'b0;
		case (s_ff.state)
			rcc_pkg::TMR_IDLE: begin
				if (issue) begin
					nxt_s.state = rcc_pkg::TMR_WAIT;
					nxt_s.cnt = '0;
				end
			end
			rcc_pkg::TMR_WAIT: begin
				if (issue) begin
					nxt_s.cnt = '0;
				end else if (ret) begin
					nxt_s.state = rcc_pkg::TMR_IDLE;
					nxt_s.cnt = '0;
				end else if (enable) begin
					if (s_ff.cnt == LAST) begin
						nxt_s.state = rcc_pkg::TMR_IDLE;
						nxt_s.cnt = '0;
						nxt_s.expire = 1'b1;
					end else begin
						nxt_s.cnt = s_ff.cnt + 1'b1;
					end
				end
				// Disabled: hold the count
			end
			default: nxt_s = '0;
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign expire = s_ff.expire;
endmodule

// ==== hdl/rcc_socket_ctrl.sv ====
// Per-socket bits of the card socket control register
module rcc_socket_ctrl (
	input  wire logic       clk,         // Clock
	input  wire logic       rst,         // Synchronous reset
	input  wire logic       wr,          // Write from this function
	input  wire logic [7:0] wdata,       // Write data
	input  wire logic       irq_event,   // Functional interrupt pulse
	output logic            video_float, // Video port float request
	output logic            spare,       // Reserved storage bit
	output logic            audio_off,   // Card audio not routed
	output logic            spk_en,      // Speaker route enable
	output logic            irq_flag     // Card interrupt flag
);
	typedef struct packed {
		logic video;
		logic spare;
		logic audio_off;
		logic spk;
		logic irq;
	} rcc_sock_t;

	rcc_sock_t s_ff;
	rcc_sock_t nxt_s;

	// Plain storage bits, then the sticky flag
	always_comb begin
		nxt_s = s_ff;
		if (wr) begin
			nxt_s.video = wdata[rcc_pkg::VIDEO_BIT];
			nxt_s.spare = wdata[rcc_pkg::SPARE_BIT];
			nxt_s.audio_off = wdata[rcc_pkg::AUDIO_BIT];
			nxt_s.spk = wdata[rcc_pkg::SPK_BIT];
		end
		if (wr && wdata[rcc_pkg::IRQ_BIT])
			nxt_s.irq = 1'b0;
		// Set after clear so a same-cycle interrupt is kept
		if (irq_event)
			nxt_s.irq = 1'b1;
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_ff.video <= rcc_pkg::CARD_RESET[rcc_pkg::VIDEO_BIT];
			s_ff.spare <= rcc_pkg::CARD_RESET[rcc_pkg::SPARE_BIT];
			s_ff.audio_off <= rcc_pkg::CARD_RESET[rcc_pkg::AUDIO_BIT];
			s_ff.spk <= rcc_pkg::CARD_RESET[rcc_pkg::SPK_BIT];
			s_ff.irq <= rcc_pkg::CARD_RESET[rcc_pkg::IRQ_BIT];
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign video_float = s_ff.video;
	assign spare       = s_ff.spare;
	assign audio_off   = s_ff.audio_off;
	assign spk_en      = s_ff.spk;
	assign irq_flag    = s_ff.irq;
endmodule

// ==== hdl/rcc_regs.sv ====
// Retry timeout status and card socket control registers, top level
module rcc_regs #(
	parameter int RETRY_LIMIT = rcc_pkg::RETRY_TIMEOUT_CLOCKS
) (
	input  wire logic       CLK,                  // 10 MHz clock
	input  wire logic       RST,                  // Synchronous reset, high
	input  wire logic       CFG_FUNC,             // Accessing function number
	input  wire logic [7:0] CFG_ADDR,             // Configuration byte offset
	input  wire logic       CFG_WR,               // Write strobe
	input  wire logic       CFG_RD,               // Read strobe
	input  wire logic [7:0] CFG_WDATA,            // Write data
	output logic      [7:0] CFG_RDATA,            // Read data, next cycle
	input  wire logic [2:0] RETRY_ISSUED,         // Retry given, per target
	input  wire logic [2:0] MASTER_RETURNED,      // Master back, per target
	input  wire logic [1:0] CARD_IRQ,             // Functional interrupt pulses
	input  wire logic [1:0] CARD_SPEAKER,         // Socket speaker levels
	input  wire logic [1:0] CARD_AUDIO,           // Socket audio levels
	input  wire logic       RING_IN,              // Ring event level
	output logic            SPEAKER_OUTPUT,       // Speaker data
	output logic            SPEAKER_OE_N,         // Speaker drive, low drives
	output logic            CARD_AUDIO_PWM,       // Audio for multipurpose pin
	output logic            AUDIO_TO_MULTIPIN,    // Audio is routed
	output logic            RING_INDICATE_OUTPUT, // Gated ring indicate
	output logic      [1:0] VIDEO_PORT_FLOAT      // Video terminals float
);

	// ****************************************************************
	// State of the block
	// ****************************************************************

	// Everything the top keeps lives in one packed struct
	typedef struct packed {
		logic       host_on;
		logic       card_on;
		logic [2:0] expired;
		logic       ring_en;
		logic [7:0] rdata;
		logic       spk_out;
		logic       spk_drive;
		logic       aud_out;
		logic       aud_routed;
		logic       ring_out;
	} rcc_top_t;

	rcc_top_t s_ff;
	rcc_top_t nxt_s;

	// ****************************************************************
	// Address decode
	// ****************************************************************

	logic       wr_retry;
	logic       wr_card;
	logic [1:0] sock_wr;

	// Both functions reach one shared retry register
	assign wr_retry = CFG_WR && (CFG_ADDR == rcc_pkg::RETRY_OFS);
	assign wr_card  = CFG_WR && (CFG_ADDR == rcc_pkg::CARD_OFS);

	// Per-socket bits go to the function that makes the access
	assign sock_wr[0] = wr_card && !CFG_FUNC;
	assign sock_wr[1] = wr_card && CFG_FUNC;

	// ****************************************************************
	// Retry timeout counters
	// ****************************************************************

	logic [2:0] tmr_on;
	logic [2:0] tmr_expire;

	// Host side on bit 7, both card targets on bit 6
	assign tmr_on[rcc_pkg::TGT_HOST]   = s_ff.host_on;
	assign tmr_on[rcc_pkg::TGT_CARD_A] = s_ff.card_on;
	assign tmr_on[rcc_pkg::TGT_CARD_B] = s_ff.card_on;

	// One counter per retried target
	generate
		for (genvar t = 0; t < rcc_pkg::NUM_TGT; t++) begin : g_tmr
			rcc_retry_timer #(
				.LIMIT  (RETRY_LIMIT)
			) u_tmr (
				.clk    (CLK),
				.rst    (RST),
				.issue  (RETRY_ISSUED[t]),
				.ret    (MASTER_RETURNED[t]),
				.enable (tmr_on[t]),
				.expire (tmr_expire[t])
			);
		end
	endgenerate

	// ****************************************************************
	// Socket slices
	// ****************************************************************

	logic [1:0] video_en;
	logic [1:0] spare_bit;
	logic [1:0] audio_off;
	logic [1:0] spk_en;
	logic [1:0] irq_flag;

	// Each socket keeps its own video, audio, speaker and flag bits
	generate
		for (genvar k = 0; k < rcc_pkg::NUM_SOCK; k++) begin : g_sock
			rcc_socket_ctrl u_sock (
				.clk         (CLK),
				.rst         (RST),
				.wr          (sock_wr[k]),
				.wdata       (CFG_WDATA),
				.irq_event   (CARD_IRQ[k]),
				.video_float (video_en[k]),
				.spare       (spare_bit[k]),
				.audio_off   (audio_off[k]),
				.spk_en      (spk_en[k]),
				.irq_flag    (irq_flag[k])
			);
		end
	endgenerate

	// ****************************************************************
	// Read values
	// ****************************************************************

	logic [7:0] retry_view;
	logic [7:0] card_view;
	logic       fsel;

	assign fsel = CFG_FUNC;

	// Reserved retry bits are tied low, not stored
	always_comb begin
		retry_view = 8'h00;
		retry_view[rcc_pkg::HOST_ON_BIT]  = s_ff.host_on;
		retry_view[rcc_pkg::CARD_ON_BIT]  = s_ff.card_on;
		retry_view[rcc_pkg::TGT_B_BIT]    = s_ff.expired[rcc_pkg::TGT_CARD_B];
		retry_view[rcc_pkg::TGT_A_BIT]    = s_ff.expired[rcc_pkg::TGT_CARD_A];
		retry_view[rcc_pkg::HOST_EXP_BIT] = s_ff.expired[rcc_pkg::TGT_HOST];
	end

	// Card bits 4 and 3 are tied low; bit 7 is global, the rest follow the function
	always_comb begin
		card_view = 8'h00;
		card_view[rcc_pkg::RING_EN_BIT] = s_ff.ring_en;
		card_view[rcc_pkg::VIDEO_BIT]   = video_en[fsel];
		card_view[rcc_pkg::SPARE_BIT]   = spare_bit[fsel];
		card_view[rcc_pkg::AUDIO_BIT]   = audio_off[fsel];
		card_view[rcc_pkg::SPK_BIT]     = spk_en[fsel];
		card_view[rcc_pkg::IRQ_BIT]     = irq_flag[fsel];
	end

	// ****************************************************************
	// Next state
	// ****************************************************************

	logic [2:0] clr_exp;
	logic       spk_mix;

	// Write-one-to-clear mask for the expiry flags
	assign clr_exp[rcc_pkg::TGT_HOST]   = wr_retry && CFG_WDATA[rcc_pkg::HOST_EXP_BIT];
	assign clr_exp[rcc_pkg::TGT_CARD_A] = wr_retry && CFG_WDATA[rcc_pkg::TGT_A_BIT];
	assign clr_exp[rcc_pkg::TGT_CARD_B] = wr_retry && CFG_WDATA[rcc_pkg::TGT_B_BIT];

	// Each socket's speaker is gated by its own enable first
	assign spk_mix = (CARD_SPEAKER[0] & spk_en[0]) ^ (CARD_SPEAKER[1] & spk_en[1]);

	always_comb begin
		nxt_s = s_ff;

		// Counter enables are plain storage
		if (wr_retry) begin
			nxt_s.host_on = CFG_WDATA[rcc_pkg::HOST_ON_BIT];
			nxt_s.card_on = CFG_WDATA[rcc_pkg::CARD_ON_BIT];
		end

		// Clear first, then set, so a timeout in the clear cycle survives
		nxt_s.expired = (s_ff.expired & ~clr_exp) | tmr_expire;

		// Ring enable is one global bit written from either function
		if (wr_card)
			nxt_s.ring_en = CFG_WDATA[rcc_pkg::RING_EN_BIT];

		// Read data captured on the strobe; unmapped offsets read zero
		if (CFG_RD) begin
			if (CFG_ADDR == rcc_pkg::RETRY_OFS)
				nxt_s.rdata = retry_view;
			else if (CFG_ADDR == rcc_pkg::CARD_OFS)
				nxt_s.rdata = card_view;
			else
				nxt_s.rdata = 8'h00;
		end

		// Speaker path, registered to keep the pin glitch free
		nxt_s.spk_out = spk_mix;
		nxt_s.spk_drive = spk_en[0] | spk_en[1];

		// Audio routing: a zero in bit 2 asks for routing
		if (!audio_off[0]) begin
			nxt_s.aud_out = CARD_AUDIO[0];
			nxt_s.aud_routed = 1'b1;
		end else if (!audio_off[1]) begin
			nxt_s.aud_out = CARD_AUDIO[1];
			nxt_s.aud_routed = 1'b1;
		end else begin
			nxt_s.aud_out = 1'b0;
			nxt_s.aud_routed = 1'b0;
		end

		// Ring indicate passes only while enabled
		nxt_s.ring_out = s_ff.ring_en & RING_IN;
	end

	// ****************************************************************
	// State register
	// ****************************************************************

	// Reset follows the printed register defaults
	always_ff @(posedge CLK) begin
		if (RST) begin
			s_ff.host_on    <= rcc_pkg::RETRY_RESET[rcc_pkg::HOST_ON_BIT];
			s_ff.card_on    <= rcc_pkg::RETRY_RESET[rcc_pkg::CARD_ON_BIT];
			s_ff.expired    <= '0;
			s_ff.ring_en    <= rcc_pkg::CARD_RESET[rcc_pkg::RING_EN_BIT];
			s_ff.rdata      <= 8'h00;
			s_ff.spk_out    <= 1'b0;
			s_ff.spk_drive  <= 1'b0;
			s_ff.aud_out    <= 1'b0;
			s_ff.aud_routed <= 1'b0;
			s_ff.ring_out   <= 1'b0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************

	// Data outputs all come straight from flip-flops
	assign CFG_RDATA            = s_ff.rdata;
	assign SPEAKER_OUTPUT       = s_ff.spk_out;
	assign SPEAKER_OE_N         = ~s_ff.spk_drive;
	assign CARD_AUDIO_PWM       = s_ff.aud_out;
	assign AUDIO_TO_MULTIPIN    = s_ff.aud_routed;
	assign RING_INDICATE_OUTPUT = s_ff.ring_out;

	// Float request only; this block never drives video data
	assign VIDEO_PORT_FLOAT     = video_en;

endmodule

// ==== test/rcc_master_model.sv ====
// Model of the bus masters that are retried and may come back later
module rcc_master_model (
	input  wire logic       clk,      // Clock
	input  wire logic [2:0] start,    // Ask for a retry, per target
	input  wire logic [7:0] delay,    // Cycles to return, zero never
	output logic      [2:0] issued,   // Retry given, per target
	output logic      [2:0] returned  // Master back, per target
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] left [3] = '{8'h00, 8'h00, 8'h00};
	initial begin
		issued = 3'h0;
		returned = 3'h0;
	end
	// One-cycle pulses; a master that never returns lets the timer run out
	always @(posedge clk) begin
		for (int t = 0; t < 3; t++) begin
			issued[t] <= start[t];
			returned[t] <= (left[t] == 8'h01);
			if (start[t])
				left[t] <= delay;
			else if (left[t] != 8'h00)
				left[t] <= left[t] - 8'h01;
		end
	end
endmodule

// ==== test/rcc_regs_asserts.sv ====
// Concurrent checks on the ports of the register block
module rcc_regs_asserts #(
	parameter int RETRY_LIMIT = 8
) (
	input wire logic       CLK,                  // Clock
	input wire logic       RST,                  // Reset
	input wire logic [7:0] CFG_ADDR,             // Offset
	input wire logic       CFG_RD,               // Read strobe
	input wire logic [7:0] CFG_RDATA,            // Read data
	input wire logic       RING_IN,              // Ring level
	input wire logic       RING_INDICATE_OUTPUT, // Ring out
	input wire logic [1:0] CARD_SPEAKER,         // Speakers
	input wire logic       SPEAKER_OUTPUT,       // Speaker data
	input wire logic       SPEAKER_OE_N,         // Speaker drive
	input wire logic [1:0] CARD_AUDIO,           // Audio levels
	input wire logic       CARD_AUDIO_PWM,       // Routed audio
	input wire logic       AUDIO_TO_MULTIPIN     // Audio routed
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	// ****************************************
	// Register reads and pin relations
	// ****************************************
	retry_rsvd_a: assert property (CFG_RD && CFG_ADDR == 8'h90 |=>
		CFG_RDATA[4] == 1'b0 && CFG_RDATA[2] == 1'b0 && CFG_RDATA[0] == 1'b0)
		else $error("retry reserved bits set");
	card_rsvd_a: assert property (CFG_RD && CFG_ADDR == 8'h91 |=> CFG_RDATA[4:3] == 2'b00)
		else $error("card reserved bits set");
	unmapped_zero_a: assert property (CFG_RD && CFG_ADDR != 8'h90 && CFG_ADDR != 8'h91
		|=> CFG_RDATA == 8'h00) else $error("unmapped read not zero");
	rdata_hold_a: assert property (!CFG_RD |=> $stable(CFG_RDATA)) else $error("read data moved");
	ring_gate_a: assert property (!RING_IN |=> !RING_INDICATE_OUTPUT)
		else $error("ring out without ring");
	spk_quiet_a: assert property (CARD_SPEAKER == 2'b00 |=> !SPEAKER_OUTPUT)
		else $error("speaker data without input");
	spk_drive_a: assert property (SPEAKER_OE_N |-> !SPEAKER_OUTPUT)
		else $error("speaker data while not driving");
	audio_off_a: assert property (!AUDIO_TO_MULTIPIN |-> !CARD_AUDIO_PWM)
		else $error("audio out while unrouted");
	audio_zero_a: assert property (CARD_AUDIO == 2'b00 |=> !CARD_AUDIO_PWM)
		else $error("audio out without input");
	// Main scenarios reached
	cover property (CFG_RD && CFG_ADDR == 8'h90 ##1 CFG_RDATA[1]);
	cover property (!SPEAKER_OE_N && SPEAKER_OUTPUT);
	cover property (AUDIO_TO_MULTIPIN && CARD_AUDIO_PWM);
endmodule

bind rcc_regs rcc_regs_asserts #(.RETRY_LIMIT(RETRY_LIMIT)) chk (.CLK(CLK), .RST(RST),
	.CFG_ADDR(CFG_ADDR), .CFG_RD(CFG_RD), .CFG_RDATA(CFG_RDATA), .RING_IN(RING_IN),
	.RING_INDICATE_OUTPUT(RING_INDICATE_OUTPUT), .CARD_SPEAKER(CARD_SPEAKER),
	.SPEAKER_OUTPUT(SPEAKER_OUTPUT), .SPEAKER_OE_N(SPEAKER_OE_N), .CARD_AUDIO(CARD_AUDIO),
	.CARD_AUDIO_PWM(CARD_AUDIO_PWM), .AUDIO_TO_MULTIPIN(AUDIO_TO_MULTIPIN));

// ==== test/rcc_regs_tb_top.sv ====
// Self-checking bench for the retry status and card control registers
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
	$display("wrong value at %0t ns: got %h expected %h", $time, g, e); end end
module rcc_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] flag_bit [3] = '{8'h02, 8'h08, 8'h20};
	logic       clk = 1'b0, rst = 1'b1, func = 1'b0, wr = 1'b0, rd = 1'b0, ring = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, delay = 8'h00, rdata;
	logic [2:0] start = 3'h0, iss, ret;
	logic [1:0] irq = 2'h0, spk = 2'h0, aud = 2'h0, vid;
	logic       spo, spoe_n, pwm, a2m, rio;
	int         errors = 0, checks = 0;
	// ****************************************
	// Clock, design and far-side masters
	// ****************************************
	initial forever #50 clk = ~clk;
	rcc_regs #(.RETRY_LIMIT(8)) uut (.CLK(clk), .RST(rst), .CFG_FUNC(func), .CFG_ADDR(addr),
		.CFG_WR(wr), .CFG_RD(rd), .CFG_WDATA(wdata), .CFG_RDATA(rdata), .RETRY_ISSUED(iss),
		.MASTER_RETURNED(ret), .CARD_IRQ(irq), .CARD_SPEAKER(spk), .CARD_AUDIO(aud),
		.RING_IN(ring), .SPEAKER_OUTPUT(spo), .SPEAKER_OE_N(spoe_n), .CARD_AUDIO_PWM(pwm),
		.AUDIO_TO_MULTIPIN(a2m), .RING_INDICATE_OUTPUT(rio), .VIDEO_PORT_FLOAT(vid));
	rcc_master_model mst (.clk(clk), .start(start), .delay(delay), .issued(iss),
		.returned(ret));
	// ****************************************
	// Access tasks and verdict
	// ****************************************
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr_reg(input logic f, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		func <= f;
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Data is registered, so it is looked at once the edge after the strobe has landed
	task automatic chk_reg(input logic f, input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		func <= f;
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask
	task automatic retry(input int t, input logic [7:0] d);
		@(posedge clk);
		start[t] <= 1'b1;
		delay <= d;
		@(posedge clk);
		start <= 3'h0;
	endtask
	task automatic results;
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Whole run is a few hundred cycles; a hang is cut off well beyond that
	initial begin
		tick(4000);
		errors++;
		results();
	end
	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		tick(6);
		rst <= 1'b0;
		chk_reg(0, 8'h90, 8'hC0);
		chk_reg(0, 8'h91, 8'h00);
		wr_reg(0, 8'h90, 8'hD5);
		chk_reg(0, 8'h90, 8'hC0);
		wr_reg(0, 8'h92, 8'hFF);
		chk_reg(0, 8'h92, 8'h00);
		// Each master stays away; the flag holds through a zero write (function 0 only)
		for (int t = 0; t < 3; t++) begin
			retry(t, 8'h00);
			tick(14);
			chk_reg(0, 8'h90, 8'hC0 | flag_bit[t]);
			wr_reg(0, 8'h90, 8'hC0);
			chk_reg(0, 8'h90, 8'hC0 | flag_bit[t]);
			wr_reg(0, 8'h90, 8'hC0 | flag_bit[t]);
			chk_reg(0, 8'h90, 8'hC0);
		end
		retry(0, 8'h04);
		tick(14);
		chk_reg(0, 8'h90, 8'hC0);
		wr_reg(0, 8'h90, 8'h00);
		retry(0, 8'h00);
		retry(1, 8'h00);
		tick(14);
		chk_reg(0, 8'h90, 8'h00);
		wr_reg(0, 8'h90, 8'hC0);
		tick(14);
		chk_reg(0, 8'h90, 8'hCA);
		wr_reg(0, 8'h90, 8'hCA);
		// Card register: per-function bits, global ring bit, video float alias
		wr_reg(0, 8'h91, 8'hFF);
		chk_reg(0, 8'h91, 8'hE6);
		chk_reg(1, 8'h91, 8'h80);
		`CHK(vid, 2'b01)
		// Socket 0 speaker off again, ring enable kept, before the speaker checks
		wr_reg(0, 8'h91, 8'h84);
		ring <= 1'b1;
		tick(3);
		#1 `CHK(rio, 1'b1)
		wr_reg(1, 8'h91, 8'h00);
		tick(3);
		#1 `CHK(rio, 1'b0)
		`CHK(spoe_n, 1'b1)
		@(posedge clk);
		spk <= 2'b11;
		tick(3);
		#1 `CHK(spoe_n, 1'b1)
		wr_reg(0, 8'h91, 8'h66);
		tick(3);
		#1 `CHK(spo, 1'b1)
		`CHK(spoe_n, 1'b0)
		wr_reg(1, 8'h91, 8'h02);
		tick(3);
		#1 `CHK(spo, 1'b0)
		@(posedge clk);
		spk <= 2'b10;
		aud <= 2'b10;
		tick(3);
		#1 `CHK(spo, 1'b1)
		`CHK({a2m, pwm}, 2'b11)
		wr_reg(0, 8'h91, 8'h02);
		tick(3);
		#1 `CHK({a2m, pwm}, 2'b10)
		@(posedge clk);
		aud <= 2'b01;
		tick(3);
		#1 `CHK({a2m, pwm}, 2'b11)
		wr_reg(0, 8'h91, 8'h04);
		wr_reg(1, 8'h91, 8'h04);
		tick(3);
		#1 `CHK({a2m, pwm, spoe_n, spo}, 4'b0010)
		// Interrupt flag is per socket and cleared by writing it back
		@(posedge clk);
		irq <= 2'b10;
		@(posedge clk);
		irq <= 2'b00;
		chk_reg(1, 8'h91, 8'h05);
		chk_reg(0, 8'h91, 8'h04);
		wr_reg(1, 8'h91, 8'h05);
		chk_reg(1, 8'h91, 8'h04);
		results();
	end
endmodule
